//--- shared/spi_buf_pkg.sv
// Purpose: constants, field layout and state type of the buffered serial peripheral
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:
package spi_buf_pkg;
	localparam logic [2:0] IDX_CTRL_A  = 3'h0;
	localparam logic [2:0] IDX_CTRL_B  = 3'h1;
	localparam logic [2:0] IDX_IRQ_EN  = 3'h2;
	localparam logic [2:0] IDX_FLAGS   = 3'h3;
	localparam logic [2:0] IDX_DATA    = 3'h4;
	localparam int         CA_ENABLE   = 0;
	localparam int         CA_HOST     = 5;
	localparam int         CB_BUF      = 7;
	localparam int         CB_WAITRX   = 6;
	localparam int         CB_SSD      = 2;
	localparam int         IE_RX       = 7;
	localparam int         IE_TX       = 6;
	localparam int         IE_EMPTY    = 5;
	localparam int         IE_SEL      = 4;
	localparam int         IE_GEN      = 0;
	localparam int         FN_XFER     = 7;
	localparam int         FN_CLASH    = 6;
	localparam int         FB_RX       = 7;
	localparam int         FB_TX       = 6;
	localparam int         FB_EMPTY    = 5;
	localparam int         FB_SEL      = 4;
	localparam int         FB_OVR      = 0;
	localparam logic [7:0] IRQ_EN_MASK = 8'hF1;
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         HALF_SCK_CYCLES = 4;

	typedef struct packed {
		logic       buf_on;
		logic       wait_rx;
		logic       select_line_disable;
		logic [1:0] mode;
	} cfg_t;

	typedef struct packed {
		logic        aw_got;
		logic [2:0]  aw_idx;
		logic        w_got;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        enable;
		logic        host;
		cfg_t        cfg;
		logic [7:0]  irq_en;
		logic        xfer_flag;
		logic        clash_flag;
		logic        arm_xfer;
		logic        arm_clash;
		logic        rx_done_st;
		logic        tx_done;
		logic        sel_lost;
		logic        overrun;
		logic        ovf_pend;
		logic        sck_s1;
		logic        sck_s2;
		logic        sck_prev;
		logic        din_s1;
		logic        din_s2;
		logic        sel_s1;
		logic        sel_s2;
		logic        busy;
		logic        primed;
		logic        shift_ok;
		logic [3:0]  bits;
		logic [7:0]  div;
		logic        sck_lvl;
		logic [7:0]  shift;
		logic        dout;
		logic [7:0]  rx_data;
		logic [7:0]  tx_buf;
		logic        tx_full;
		logic [7:0]  rx_buf;
		logic        rx_full;
		logic [7:0]  rx_pend;
		logic        pend_full;
	} state_t;
endpackage

//--- hdl/spi_buf_core.sv
// Purpose: serial host/client peripheral with buffer mode, flags and AXI4-Lite registers
// Assumes: aclk domain only; serial pins sampled through two flip-flops
// Notes: msb first; host clock is aclk divided by 2 * HALF_CYCLES
`timescale 1ns/100ps
`default_nettype none
module spi_buf_core
	import spi_buf_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_SCK_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	input  wire logic        select_n_in,
	output logic             irq
);
	state_t s;
	state_t n;

	logic       wr_fire;
	logic       rd_fire;
	logic [2:0] rd_idx;
	logic       cpol;
	logic       cpha;
	logic       lead;
	logic       trail;
	logic       smp;
	logic       setup;
	logic       done;
	logic [3:0] nbits;
	logic       mid_byte;
	logic       client_sel;
	logic       data_wr;
	logic       data_rd;
	logic [7:0] d;
	logic [7:0] rx_byte;

	// register read value for one index
	function automatic logic [7:0] reg_value(input state_t st, input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			IDX_CTRL_A:
			begin
				v[CA_ENABLE] = st.enable;
				v[CA_HOST] = st.host;
			end
			IDX_CTRL_B:
			begin
				v[CB_BUF] = st.cfg.buf_on;
				v[CB_WAITRX] = st.cfg.wait_rx;
				v[CB_SSD] = st.cfg.select_line_disable;
				v[1:0] = st.cfg.mode;
			end
			IDX_IRQ_EN:
			begin
				v = st.irq_en & IRQ_EN_MASK;
				if (!st.cfg.buf_on)
					v[7:4] = 4'h0;
			end
			IDX_FLAGS:
			begin
				if (st.cfg.buf_on)
				begin
					v[FB_RX] = st.rx_done_st & st.rx_full;
					v[FB_TX] = st.tx_done;
					v[FB_EMPTY] = ~st.tx_full;
					v[FB_SEL] = st.sel_lost;
					v[FB_OVR] = st.overrun;
				end
				else
				begin
					v[FN_XFER] = st.xfer_flag;
					v[FN_CLASH] = st.clash_flag;
				end
			end
			IDX_DATA:
				v = st.cfg.buf_on ? st.rx_buf : st.rx_data;
			default:
				v = 8'h00;
		endcase
		return v;
	endfunction

	assign s_axi_awready = ~s.aw_got & ~s.bvalid;
	assign s_axi_wready  = ~s.w_got & ~s.bvalid;
	assign s_axi_arready = ~s.rvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	assign cpol       = s.cfg.mode[1];
	assign cpha       = s.cfg.mode[0];
	assign client_sel = s.enable & ~s.host & ~s.sel_s2;
	assign sck_out    = s.sck_lvl;
	assign sck_oe     = s.enable & s.host;
	assign mosi_out   = s.dout;
	assign mosi_oe    = s.enable & s.host;
	assign miso_out   = s.dout;
	assign miso_oe    = client_sel;

	always_comb
	begin
		if (s.cfg.buf_on)
			irq = (s.irq_en[IE_RX] & s.rx_done_st & s.rx_full)
				| (s.irq_en[IE_TX] & s.tx_done)
				| (s.irq_en[IE_EMPTY] & ~s.tx_full)
				| (s.irq_en[IE_SEL] & s.sel_lost);
		else
			irq = s.irq_en[IE_GEN] & s.xfer_flag;
	end

	always_comb
	begin
		n = s;
		rd_idx = s_axi_araddr[4:2];
		wr_fire = s.aw_got & s.w_got & ~s.bvalid;
		rd_fire = s_axi_arvalid & ~s.rvalid;
		d = s.wdata;
		data_wr = wr_fire & s.wstrb0 & (s.aw_idx == IDX_DATA);
		data_rd = rd_fire & (rd_idx == IDX_DATA);
		mid_byte = s.host ? s.busy : (s.bits != 4'h0);
		lead = 1'b0;
		trail = 1'b0;
		rx_byte = s.shift;

		// input synchronisers
		n.sck_s1 = sck_in;
		n.sck_s2 = s.sck_s1;
		n.sck_prev = s.sck_s2;
		n.din_s1 = s.host ? miso_in : mosi_in;
		n.din_s2 = s.din_s1;
		n.sel_s1 = select_n_in;
		n.sel_s2 = s.sel_s1;

		// bus address and data capture, either order
		if (s_axi_awvalid & s_axi_awready)
		begin
			n.aw_got = 1'b1;
			n.aw_idx = s_axi_awaddr[4:2];
		end
		if (s_axi_wvalid & s_axi_wready)
		begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata[7:0];
			n.wstrb0 = s_axi_wstrb[0];
		end
		if (s.bvalid & s_axi_bready)
			n.bvalid = 1'b0;
		if (s.rvalid & s_axi_rready)
			n.rvalid = 1'b0;

		if (rd_fire)
		begin
			n.rvalid = 1'b1;
			n.rdata = {24'h000000, reg_value(s, rd_idx)};
			n.rresp = (rd_idx > IDX_DATA) ? RESP_SLVERR : RESP_OKAY;
			if (rd_idx == IDX_FLAGS && !s.cfg.buf_on)
			begin
				n.arm_xfer = s.xfer_flag;
				n.arm_clash = s.clash_flag;
			end
		end

		// register writes; clears first so hardware sets below win
		if (wr_fire)
		begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = (s.aw_idx > IDX_DATA) ? RESP_SLVERR : RESP_OKAY;
			if (s.wstrb0)
			begin
				unique case (s.aw_idx)
					IDX_CTRL_A:
					begin
						n.enable = d[CA_ENABLE];
						n.host = d[CA_HOST];
					end
					IDX_CTRL_B:
					begin
						n.cfg.buf_on = d[CB_BUF];
						n.cfg.wait_rx = d[CB_WAITRX];
						n.cfg.select_line_disable = d[CB_SSD];
						n.cfg.mode = d[1:0];
					end
					IDX_IRQ_EN:
						n.irq_en = d & IRQ_EN_MASK;
					IDX_FLAGS:
					begin
						if (s.cfg.buf_on)
						begin
							if (d[FB_RX])
								n.rx_done_st = 1'b0;
							if (d[FB_TX])
								n.tx_done = 1'b0;
							if (d[FB_SEL])
								n.sel_lost = 1'b0;
							if (d[FB_OVR])
							begin
								n.overrun = 1'b0;
								n.ovf_pend = 1'b0;
							end
						end
						else if (d[FN_XFER])
							n.xfer_flag = 1'b0;
					end
					default:
					begin
					end
				endcase
			end
		end

		if (!n.enable || !n.cfg.buf_on)
			n.primed = 1'b0;

		// flag-read then data-access clear sequence
		if ((data_wr || data_rd) && !s.cfg.buf_on)
		begin
			if (s.arm_xfer)
				n.xfer_flag = 1'b0;
			if (s.arm_clash)
				n.clash_flag = 1'b0;
			n.arm_xfer = 1'b0;
			n.arm_clash = 1'b0;
		end

		// buffer-mode read pops the receive buffer
		if (data_rd && s.cfg.buf_on)
		begin
			n.overrun = 1'b0;
			if (s.pend_full)
			begin
				n.rx_buf = s.rx_pend;
				n.pend_full = 1'b0;
			end
			else
				n.rx_full = 1'b0;
		end

		// data writes
		if (data_wr)
		begin
			if (!s.cfg.buf_on)
			begin
				if (mid_byte)
					n.clash_flag = 1'b1;
				else
				begin
					n.shift = d;
					n.dout = d[7];
					n.shift_ok = 1'b1;
				end
			end
			else if (s.cfg.wait_rx && !s.primed && s.enable && s.sel_s2 && !mid_byte)
			begin
				n.shift = d;
				n.dout = d[7];
				n.shift_ok = 1'b1;
				n.primed = 1'b1;
			end
			else
			begin
				n.tx_buf = d;
				n.tx_full = 1'b1;
			end
		end

		// load the shift register: buffered byte once primed or with wait_rx, else 0x00
		if (s.cfg.buf_on && s.enable && s.tx_full && !s.shift_ok && !mid_byte && !data_wr)
		begin
			n.shift_ok = 1'b1;
			n.primed = 1'b1;
			if (s.primed || s.cfg.wait_rx)
			begin
				n.shift = s.tx_buf;
				n.dout = s.tx_buf[7];
				n.tx_full = 1'b0;
			end
			else
			begin
				n.shift = 8'h00;
				n.dout = 1'b0;
			end
		end

		// host start
		if (s.enable && s.host && s.shift_ok && !s.busy)
		begin
			n.busy = 1'b1;
			n.shift_ok = 1'b0;
			n.bits = 4'h0;
			n.div = 8'h00;
			if (s.ovf_pend)
			begin
				n.overrun = 1'b1;
				n.ovf_pend = 1'b0;
			end
		end

		// serial clock edges
		if (s.host && s.busy)
		begin
			n.div = s.div + 8'h01;
			if (s.div == 8'(HALF_CYCLES - 1))
			begin
				n.div = 8'h00;
				n.sck_lvl = ~s.sck_lvl;
				lead = (s.sck_lvl == cpol);
				trail = ~lead;
			end
		end
		else
		begin
			if (!s.busy)
				n.sck_lvl = cpol;
			if (client_sel)
			begin
				lead = cpol ? (s.sck_prev & ~s.sck_s2) : (~s.sck_prev & s.sck_s2);
				trail = cpol ? (~s.sck_prev & s.sck_s2) : (s.sck_prev & ~s.sck_s2);
			end
		end

		smp = cpha ? trail : lead;
		setup = cpha ? lead : trail;
		nbits = s.bits + {3'h0, smp};
		done = trail & (nbits == 4'h8);
		if (lead && !s.host && s.bits == 4'h0 && s.ovf_pend)
		begin
			n.overrun = 1'b1;
			n.ovf_pend = 1'b0;
		end
		if (smp)
		begin
			n.shift = {s.shift[6:0], s.din_s2};
			rx_byte = {s.shift[6:0], s.din_s2};
			n.bits = nbits;
		end
		if (setup && !done)
			n.dout = s.shift[7];

		if (done)
		begin
			n.bits = 4'h0;
			n.busy = 1'b0;
			n.shift_ok = 1'b0;
			if (!s.cfg.buf_on)
			begin
				n.rx_data = rx_byte;
				n.xfer_flag = 1'b1;
			end
			else
			begin
				if (!n.rx_full)
				begin
					n.rx_buf = rx_byte;
					n.rx_full = 1'b1;
					n.rx_done_st = 1'b1;
				end
				else if (!n.pend_full)
				begin
					n.rx_pend = rx_byte;
					n.pend_full = 1'b1;
					n.rx_done_st = 1'b1;
				end
				else if (n.tx_full)
					n.overrun = 1'b1;
				else
					n.ovf_pend = 1'b1;
				if (!n.tx_full)
					n.tx_done = 1'b1;
			end
		end

		// client deselect resets the bit counter
		if (!s.host && s.sel_s2)
			n.bits = 4'h0;

		// select pulled low while host
		if (s.enable && s.host && !s.cfg.select_line_disable && !s.sel_s2)
		begin
			n.host = 1'b0;
			n.busy = 1'b0;
			n.bits = 4'h0;
			n.sck_lvl = cpol;
			if (s.cfg.buf_on)
				n.sel_lost = 1'b1;
			else
				n.xfer_flag = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.sck_s1 <= 1'b0;
			s.sel_s1 <= 1'b1;
			s.sel_s2 <= 1'b1;
			s.irq_en <= REG_RESET;
		end
		else
			s <= n;
	end
endmodule
`default_nettype wire

//--- dv/spi_buf_props.sv
// Purpose: register bus and serial clock checks on the peripheral ports
// Assumes: one clock domain, reset synchronous and active low
// Notes: attached by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module spi_buf_props
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        sck_out,
	input wire logic        sck_oe
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_bresp_after: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write response before both halves held");
	a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bytes set");
	a_read_lat: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	a_sck_half: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
		else $error("serial clock half period too short");
endmodule
bind spi_buf_core spi_buf_props u_props (.*);
`default_nettype wire

//--- dv/spi_client_model.sv
// Purpose: serial client on the far side of the peripheral
// Assumes: clock mode 0, host clock idles low
// Notes: reload toggles load a byte; from the eighth through the fifteenth falling edge the line toggles on each fall
`timescale 1ns/100ps
`default_nettype none
module spi_client_model
(
	input wire logic        sck,
	input wire logic        mosi,
	input wire logic        reload,
	input wire logic [7:0]  tx_byte,
	output logic            miso,
	output logic [7:0]      rx_byte,
	output logic [15:0]     bit_count
);
	logic [7:0] shifter = 8'h00;
	logic [3:0] falls = 4'h0;
	initial
	begin
		miso = 1'b0;
		rx_byte = 8'h00;
		bit_count = 16'h0000;
	end
	always @(reload)
	begin
		shifter = tx_byte;
		miso = tx_byte[7];
		falls = 4'h0;
	end
	always @(posedge sck)
	begin
		rx_byte <= {rx_byte[6:0], mosi};
		bit_count <= bit_count + 16'h0001;
	end
	always @(negedge sck)
	begin
		shifter = {shifter[6:0], 1'b0};
		falls = falls + 4'h1;
		miso = (falls >= 4'h8) ? ~miso : shifter[7];
	end
endmodule
`default_nettype wire

//--- dv/test_spi_buf_core.sv
// Purpose: self-checking bench of the buffered serial peripheral
// Assumes: host role against one mode 0 client, then client role in mode 0 with the bench as host
// Notes: random bytes from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module test_spi_buf_core
	import spi_buf_pkg::*;
;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        rdy = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        sel_n = 1'b1, ld = 1'b0;
	logic        sck_h = 1'b0, mosi_h = 1'b0;
	logic        sck_e, mosi_e, miso_o, miso_e;
	logic [7:0]  got, c;
	logic [7:0]  ptx = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid, sck, mosi, miso, irq;
	logic [1:0]  bresp, rresp, rr;
	logic [31:0] rdata, rd;
	logic [7:0]  prx, p, b, pq [2];
	logic [15:0] pbits, b0;
	int          err_count = 0, num_checks = 0, cyc = 0;

	spi_buf_core #(.HALF_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb({4{rdy}}), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(rdy),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rdy),
		.sck_in(sck_h), .sck_out(sck), .sck_oe(sck_e), .mosi_in(mosi_h), .mosi_out(mosi),
		.mosi_oe(mosi_e), .miso_in(miso), .miso_out(miso_o), .miso_oe(miso_e),
		.select_n_in(sel_n), .irq(irq));
	spi_client_model peer (.sck(sck), .mosi(mosi), .reload(ld), .tx_byte(ptx),
		.miso(miso), .rx_byte(prx), .bit_count(pbits));

	always #20 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 32'h9C40)
		begin
			err_count++;
			report_and_stop();
		end
	end

	function automatic logic [7:0] ie_view(input logic [7:0] en, input logic bufm);
		return bufm ? (en & IRQ_EN_MASK) : (en & 8'h01);
	endfunction
	// rising leading edge modes idle low
	function automatic logic idle_lvl(input logic [1:0] m);
		return m[1];
	endfunction

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		awaddr <= {27'h0, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		if (n >= 50)
			err_count++;
	endtask
	task automatic rd_reg(input logic [2:0] idx);
		int n;
		n = 0;
		araddr <= {27'h0, idx, 2'b00};
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		rd = rdata;
		rr = rresp;
		if (n >= 50)
			err_count++;
	endtask
	task automatic rc(input logic [2:0] idx, input logic [7:0] m, input logic [7:0] e);
		rd_reg(idx);
		chk(rd & {24'h0, m}, {24'h0, e});
	endtask
	task automatic wf(input int bitn);
		int n;
		n = 0;
		do
		begin
			rd_reg(IDX_FLAGS);
			n++;
		end
		while (rd[bitn] !== 1'b1 && n < 200);
		if (n >= 200)
			err_count++;
	endtask
	task automatic xfer();
		p = 8'($urandom);
		b = 8'($urandom);
		ptx <= p;
		ld <= ~ld;
		wr(IDX_DATA, b);
	endtask
	task automatic drop_sel();
		sel_n <= 1'b0;
		repeat (6) @(posedge aclk);
		sel_n <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask

	initial
	begin
		b = 8'($urandom(75));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdy <= 1'b1;
		@(posedge aclk);
		rc(IDX_IRQ_EN, 8'hFF, 8'h00);
		rc(IDX_FLAGS, 8'hFF, 8'h00);
		rc(IDX_DATA, 8'hFF, 8'h00);
		rc(3'h7, 8'hFF, 8'h00);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		for (int m = 0; m < 4; m++)
		begin
			wr(IDX_CTRL_B, 8'(m));
			rc(IDX_CTRL_B, 8'h03, 8'(m));
			chk({31'h0, sck}, {31'h0, idle_lvl(2'(m))});
		end
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_IRQ_EN, 8'hF1);
		rc(IDX_IRQ_EN, 8'hFF, ie_view(8'hF1, 1'b0));
		wr(IDX_CTRL_A, 8'h21);
		chk({30'h0, sck_e, mosi_e}, 32'h3);
		xfer();
		wf(FN_XFER);
		chk({24'h0, prx}, {24'h0, b});
		chk({31'h0, irq}, 32'h1);
		rc(IDX_DATA, 8'hFF, p);
		rc(IDX_FLAGS, 8'hFF, 8'h00);
		chk({31'h0, irq}, 32'h0);
		xfer();
		repeat (4) @(posedge aclk);
		wr(IDX_DATA, ~b);
		wf(FN_XFER);
		chk(rd & 32'hC0, 32'hC0);
		chk({24'h0, prx}, {24'h0, b});
		rc(IDX_DATA, 8'hFF, p);
		rc(IDX_FLAGS, 8'hFF, 8'h00);
		wr(IDX_CTRL_B, 8'h04);
		drop_sel();
		rc(IDX_CTRL_A, 8'hFF, 8'h21);
		wr(IDX_CTRL_B, 8'h00);
		drop_sel();
		rc(IDX_CTRL_A, 8'hFF, 8'h01);
		rc(IDX_FLAGS, 8'hFF, 8'h80);
		wr(IDX_FLAGS, 8'h80);
		rc(IDX_FLAGS, 8'hFF, 8'h00);
		wr(IDX_CTRL_B, 8'h80);
		rc(IDX_IRQ_EN, 8'hFF, ie_view(8'hF1, 1'b1));
		rc(IDX_FLAGS, 8'hFF, 8'h20);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_IRQ_EN, 8'h00);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_CTRL_A, 8'h21);
		drop_sel();
		rc(IDX_FLAGS, 8'h10, 8'h10);
		wr(IDX_FLAGS, 8'h10);
		rc(IDX_FLAGS, 8'h10, 8'h00);
		wr(IDX_CTRL_A, 8'h21);
		b0 = pbits;
		xfer();
		wf(FB_TX);
		chk({16'h0, pbits - b0}, 32'h10);
		chk({24'h0, prx}, {24'h0, b});
		wr(IDX_FLAGS, 8'hFF);
		rd_reg(IDX_DATA);
		rd_reg(IDX_DATA);
		wr(IDX_CTRL_A, 8'h00);
		wr(IDX_CTRL_B, 8'hC0);
		wr(IDX_CTRL_A, 8'h21);
		for (int i = 0; i < 4; i++)
		begin
			b0 = pbits;
			xfer();
			wf(FB_TX);
			if (i < 2)
				pq[i] = p;
			chk({16'h0, pbits - b0}, 32'h8);
			chk({24'h0, prx}, {24'h0, b});
			wr(IDX_FLAGS, 8'h40);
			rc(IDX_FLAGS, 8'h41, (i == 3) ? 8'h01 : 8'h00);
		end
		rc(IDX_FLAGS, 8'h80, 8'h80);
		rc(IDX_DATA, 8'hFF, pq[0]);
		rc(IDX_FLAGS, 8'h01, 8'h00);
		rc(IDX_DATA, 8'hFF, pq[1]);
		rc(IDX_FLAGS, 8'h80, 8'h00);
		// client role, mode 0: bench acts as the external host
		wr(IDX_CTRL_A, 8'h00);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_CTRL_A, 8'h01);
		chk({31'h0, miso_e}, 32'h0);
		sel_n <= 1'b0;
		b = 8'($urandom);
		c = 8'($urandom);
		wr(IDX_DATA, b);
		chk({31'h0, miso_e}, 32'h1);
		for (int k = 7; k >= 0; k--)
		begin
			mosi_h <= c[k];
			repeat (4) @(posedge aclk);
			got[k] = miso_o;
			sck_h <= 1'b1;
			repeat (4) @(posedge aclk);
			sck_h <= 1'b0;
		end
		repeat (6) @(posedge aclk);
		sel_n <= 1'b1;
		chk({24'h0, got}, {24'h0, b});
		rc(IDX_FLAGS, 8'h80, 8'h80);
		rc(IDX_DATA, 8'hFF, c);
		report_and_stop();
	end
endmodule
`default_nettype wire
